/* File: logic/nvc_pkg.sv */
package nvc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TP_W = 22;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_TPTR = 12'h004;
  // Control register field positions.
  localparam int B_PDSEL = 7;
  localparam int B_CFGSEL = 6;
  localparam int B_UNIMPL = 5;
  localparam int B_ROWERASE = 4;
  localparam int B_WERR = 3;
  localparam int B_WALLOW = 2;
  localparam int B_WRCMD = 1;
  localparam int B_RDCMD = 0;
  // Reset values.
  localparam logic [TP_W-1:0] TPTR_RST = 22'h000000;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;
  typedef enum logic [1:0] {
    TGT_EEPROM = 2'b00,
    TGT_FLASH  = 2'b01,
    TGT_CONFIG = 2'b10
  } nvc_target_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } nvc_state_t;
endpackage

/* File: logic/nvc_ctrl.sv */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Config select one targets configuration registers.
// - Bit five always reads as zero.
// - Row erase set makes next write erase.
// - Hardware clears row erase after erase completes.
// - Row erase clear means write only.
// - Program/data select picks flash or EEPROM.
// - Error flag set on abort or improper write.
// - Abort leaves both select bits unchanged.
// - Write and erase only with write allow.
module nvc_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [nvc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [nvc_pkg::DATA_W-1:0] pwdata,
  output logic      [nvc_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic      [nvc_pkg::TP_W-1:0]   tablePointer,
  output nvc_pkg::nvc_target_t            memTarget,
  output logic                            opStart,
  output logic                            opErase,
  output logic                            rdStart,
  output logic                            opBusy,
  input  wire logic                       opDone,
  input  wire logic                       opAbort
);

  logic                     pdSel_q,     pdSel_d;
  logic                     cfgSel_q,    cfgSel_d;
  logic                     rowErase_q,  rowErase_d;
  logic                     werr_q,      werr_d;
  logic                     wAllow_q,    wAllow_d;
  logic [nvc_pkg::TP_W-1:0] tptr_q,      tptr_d;
  logic                     start_q,     start_d;
  logic                     erase_q,     erase_d;
  logic                     rd_q,        rd_d;
  logic [nvc_pkg::DATA_W-1:0] rdata_q,   rdata_d;
  logic                     err_q,       err_d;
  nvc_pkg::nvc_state_t      state_q,     state_d;

  logic wrCtrl;
  logic wrTptr;
  logic mapped;
  logic nextAllow;
  logic nextErase;

  function automatic logic is_mapped(input logic [nvc_pkg::ADDR_W-1:0] a);
    is_mapped = (a == nvc_pkg::ADDR_CTRL) || (a == nvc_pkg::ADDR_TPTR);
  endfunction

  function automatic logic [nvc_pkg::DATA_W-1:0] ctrl_word(
    input logic pd, input logic cfg, input logic re, input logic we,
    input logic wa, input logic busy);
    logic [nvc_pkg::DATA_W-1:0] w;
    w = nvc_pkg::RDATA_ZERO;
    w[nvc_pkg::B_PDSEL]    = pd;
    w[nvc_pkg::B_CFGSEL]   = cfg;
    w[nvc_pkg::B_ROWERASE] = re;
    w[nvc_pkg::B_WERR]     = we;
    w[nvc_pkg::B_WALLOW]   = wa;
    w[nvc_pkg::B_WRCMD]    = busy;
    // The unimplemented position keeps the zero from the cleared word.
    ctrl_word = w;
    return w;
  endfunction

  // Zero wait states: every access completes in its first access cycle.
  assign pready  = penable;
  assign pslverr = err_q & penable;
  assign prdata  = rdata_q;
  assign tablePointer = tptr_q;
  assign opStart = start_q;
  assign opErase = erase_q;
  assign rdStart = rd_q;
  assign opBusy  = (state_q == nvc_pkg::ST_BUSY);

  always_comb begin
    wrCtrl = psel & penable & pwrite & (paddr == nvc_pkg::ADDR_CTRL);
    wrTptr = psel & penable & pwrite & (paddr == nvc_pkg::ADDR_TPTR);
    mapped = is_mapped(paddr);
    nextAllow = wrCtrl ? pwdata[nvc_pkg::B_WALLOW] : wAllow_q;
    nextErase = wrCtrl ? pwdata[nvc_pkg::B_ROWERASE] : rowErase_q;
  end

  // Memory routing follows the two select bits.
  always_comb begin
    if (cfgSel_q) begin
      memTarget = nvc_pkg::TGT_CONFIG;
    end else if (pdSel_q) begin
      memTarget = nvc_pkg::TGT_FLASH;
    end else begin
      memTarget = nvc_pkg::TGT_EEPROM;
    end
  end

  // Register file and command sequencing.
  always_comb begin
    pdSel_d    = pdSel_q;
    cfgSel_d   = cfgSel_q;
    rowErase_d = rowErase_q;
    werr_d     = werr_q;
    wAllow_d   = wAllow_q;
    tptr_d     = tptr_q;
    start_d    = 1'b0;
    erase_d    = erase_q;
    rd_d       = 1'b0;
    state_d    = state_q;
    if (wrCtrl) begin
      // Bit five has no storage, so its written value is simply dropped.
      pdSel_d    = pwdata[nvc_pkg::B_PDSEL];
      cfgSel_d   = pwdata[nvc_pkg::B_CFGSEL];
      rowErase_d = pwdata[nvc_pkg::B_ROWERASE];
      wAllow_d   = pwdata[nvc_pkg::B_WALLOW];
      // Software may only clear the error flag.
      if (!pwdata[nvc_pkg::B_WERR]) begin
        werr_d = 1'b0;
      end
      if (pwdata[nvc_pkg::B_RDCMD] && state_q == nvc_pkg::ST_IDLE) begin
        rd_d = 1'b1;
      end
    end
    if (wrTptr) begin
      tptr_d = pwdata[nvc_pkg::TP_W-1:0];
    end
    case (state_q)
      nvc_pkg::ST_IDLE: begin
        if (wrCtrl && pwdata[nvc_pkg::B_WRCMD]) begin
          if (nextAllow) begin
            start_d = 1'b1;
            erase_d = nextErase;
            state_d = nvc_pkg::ST_BUSY;
          end else begin
            werr_d = 1'b1;
          end
        end
      end
      nvc_pkg::ST_BUSY: begin
        if (opAbort) begin
          // Selects stay as they were so software can trace the failure.
          werr_d  = 1'b1;
          state_d = nvc_pkg::ST_IDLE;
        end else if (opDone) begin
          werr_d  = 1'b0;
          state_d = nvc_pkg::ST_IDLE;
          if (erase_q && !wrCtrl) begin
            rowErase_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = nvc_pkg::ST_IDLE;
      end
    endcase
  end

  // Read data and error answer are captured in the setup cycle.
  always_comb begin
    rdata_d = rdata_q;
    err_d   = 1'b0;
    if (psel && !penable) begin
      err_d = ~mapped;
      if (pwrite || !mapped) begin
        rdata_d = nvc_pkg::RDATA_ZERO;
      end else if (paddr == nvc_pkg::ADDR_CTRL) begin
        rdata_d = ctrl_word(pdSel_q, cfgSel_q, rowErase_q, werr_q,
                            wAllow_q, state_q == nvc_pkg::ST_BUSY);
      end else begin
        rdata_d = {{(nvc_pkg::DATA_W-nvc_pkg::TP_W){1'b0}}, tptr_q};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pdSel_q    <= 1'b0;
      cfgSel_q   <= 1'b0;
      rowErase_q <= 1'b0;
      werr_q     <= 1'b0;
      wAllow_q   <= 1'b0;
      tptr_q     <= nvc_pkg::TPTR_RST;
      start_q    <= 1'b0;
      erase_q    <= 1'b0;
      rd_q       <= 1'b0;
      rdata_q    <= nvc_pkg::RDATA_ZERO;
      err_q      <= 1'b0;
      state_q    <= nvc_pkg::ST_IDLE;
    end else begin
      pdSel_q    <= pdSel_d;
      cfgSel_q   <= cfgSel_d;
      rowErase_q <= rowErase_d;
      werr_q     <= werr_d;
      wAllow_q   <= wAllow_d;
      tptr_q     <= tptr_d;
      start_q    <= start_d;
      erase_q    <= erase_d;
      rd_q       <= rd_d;
      rdata_q    <= rdata_d;
      err_q      <= err_d;
      state_q    <= state_d;
    end
  end

  sequence s_ctrl_read;
    psel && !penable && !pwrite && paddr == nvc_pkg::ADDR_CTRL;
  endsequence

  sequence s_erase_done;
    state_q == nvc_pkg::ST_BUSY && opDone && !opAbort && erase_q && !wrCtrl;
  endsequence

  sequence s_abort;
    state_q == nvc_pkg::ST_BUSY && opAbort && !wrCtrl;
  endsequence

  a_cfg_target: assert property (@(posedge core_clk) disable iff (rst)
    cfgSel_q |-> memTarget == nvc_pkg::TGT_CONFIG)
    else $error("config select does not reach config space");

  a_pd_target: assert property (@(posedge core_clk) disable iff (rst)
    !cfgSel_q |-> memTarget == (pdSel_q ? nvc_pkg::TGT_FLASH
                                        : nvc_pkg::TGT_EEPROM))
    else $error("program/data select routes wrongly");

  a_bit5_zero: assert property (@(posedge core_clk) disable iff (rst)
    s_ctrl_read |=> prdata[nvc_pkg::B_UNIMPL] == 1'b0)
    else $error("unimplemented bit reads nonzero");

  a_bit5_void: assert property (@(posedge core_clk) disable iff (rst)
    wrCtrl && pwdata[nvc_pkg::B_UNIMPL] ##[1:4] s_ctrl_read
      |=> prdata[nvc_pkg::B_UNIMPL] == 1'b0)
    else $error("write to unimplemented bit was stored");

  a_erase_start: assert property (@(posedge core_clk) disable iff (rst)
    state_q == nvc_pkg::ST_IDLE && wrCtrl && pwdata[nvc_pkg::B_WRCMD]
      && pwdata[nvc_pkg::B_WALLOW] && pwdata[nvc_pkg::B_ROWERASE]
      |=> opStart && opErase)
    else $error("row erase set but no erase started");

  a_erase_clear: assert property (@(posedge core_clk) disable iff (rst)
    s_erase_done |=> !rowErase_q && !opBusy)
    else $error("row erase not cleared after erase");

  a_write_only: assert property (@(posedge core_clk) disable iff (rst)
    state_q == nvc_pkg::ST_IDLE && wrCtrl && pwdata[nvc_pkg::B_WRCMD]
      && pwdata[nvc_pkg::B_WALLOW] && !pwdata[nvc_pkg::B_ROWERASE]
      |=> opStart && !opErase)
    else $error("erase issued with row erase clear");

  a_err_abort: assert property (@(posedge core_clk) disable iff (rst)
    s_abort |=> werr_q ##1 (werr_q || $past(wrCtrl)))
    else $error("abort did not set error flag");

  a_err_keep: assert property (@(posedge core_clk) disable iff (rst)
    s_abort |=> $stable(pdSel_q) && $stable(cfgSel_q))
    else $error("select bits changed on write error");

  a_allow_gate: assert property (@(posedge core_clk) disable iff (rst)
    state_q == nvc_pkg::ST_IDLE && wrCtrl && pwdata[nvc_pkg::B_WRCMD]
      && !pwdata[nvc_pkg::B_WALLOW] |=> !opStart && !opBusy && werr_q)
    else $error("write started without write allow");

  // A completion that is not cut short leaves a clean error flag.
  sequence s_done;
    state_q == nvc_pkg::ST_BUSY && opDone && !opAbort;
  endsequence

  a_done_clear: assert property (@(posedge core_clk) disable iff (rst)
    s_done |=> !werr_q && !opBusy)
    else $error("error flag not cleared on completion");

  // An abort in the same cycle as a software clear still sets the flag.
  a_abort_set: assert property (@(posedge core_clk) disable iff (rst)
    state_q == nvc_pkg::ST_BUSY && opAbort |=> werr_q && !opBusy)
    else $error("abort in clear cycle lost the error flag");

  a_abort_free: assert property (@(posedge core_clk) disable iff (rst)
    s_abort |=> rowErase_q == $past(rowErase_q))
    else $error("abort changed the row erase bit");

  // Only software moves the selects; no operation event may touch them.
  a_sel_sw_only: assert property (@(posedge core_clk) disable iff (rst)
    !wrCtrl |=> $stable(pdSel_q) && $stable(cfgSel_q))
    else $error("select bits changed without a write");

  a_start_busy: assert property (@(posedge core_clk) disable iff (rst)
    opStart |-> opBusy)
    else $error("start pulse without busy state");

  a_busy_refuse: assert property (@(posedge core_clk) disable iff (rst)
    state_q == nvc_pkg::ST_BUSY && wrCtrl && pwdata[nvc_pkg::B_WRCMD]
      |=> !opStart)
    else $error("write command taken while busy");

  // The row to erase is the one the pointer holds once software loads it.
  a_tptr_load: assert property (@(posedge core_clk) disable iff (rst)
    wrTptr |=> tablePointer == $past(pwdata[nvc_pkg::TP_W-1:0]))
    else $error("table pointer not loaded");

  a_rd_pulse: assert property (@(posedge core_clk) disable iff (rst)
    state_q == nvc_pkg::ST_IDLE && wrCtrl && pwdata[nvc_pkg::B_RDCMD]
      |=> rdStart)
    else $error("read command gave no read pulse");

endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic                       core_clk;
  logic                       rst;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [nvc_pkg::ADDR_W-1:0] paddr;
  logic [nvc_pkg::DATA_W-1:0] pwdata;
  logic [nvc_pkg::DATA_W-1:0] prdata;
  logic                       pready;
  logic                       pslverr;
  logic [nvc_pkg::TP_W-1:0]   tablePointer;
  nvc_pkg::nvc_target_t       memTarget;
  logic                       opStart;
  logic                       opErase;
  logic                       rdStart;
  logic                       opBusy;
  logic                       opDone;
  logic                       opAbort;
  int                         errors;
  int                         testsRun;
  int                         starts;
  int                         reads;
  logic                       lastErase;
  logic [31:0]                rd;
  logic                       err;

  nvc_ctrl dut_u (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tablePointer(tablePointer), .memTarget(memTarget), .opStart(opStart),
    .opErase(opErase), .rdStart(rdStart), .opBusy(opBusy),
    .opDone(opDone), .opAbort(opAbort));

  always #2 core_clk = ~core_clk;

  // Pulses are counted here so that no one-cycle output is missed.
  always @(posedge core_clk) begin
    if (opStart === 1'b1) begin
      starts++;
      lastErase = opErase;
    end
    if (rdStart === 1'b1) reads++;
  end

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask

  // Ends an operation with a one-cycle completion or abort pulse.
  task automatic finish_op(input logic abort);
    int n;
    @(posedge core_clk);
    opDone  <= !abort;
    opAbort <= abort;
    @(posedge core_clk);
    opDone  <= 1'b0;
    opAbort <= 1'b0;
    n = 0;
    while (opBusy !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      conclude();
    end
  endtask

  task automatic ctrl(input logic [31:0] d, input logic [31:0] exp);
    apb(1'b1, nvc_pkg::ADDR_CTRL, d);
    apb(1'b0, nvc_pkg::ADDR_CTRL, 32'h00000000);
    check("ctrl", rd, exp);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, opDone, opAbort} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {errors, testsRun, starts, reads} = '0;
    lastErase = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, nvc_pkg::ADDR_CTRL, 32'h00000000);
    check("ctrl reset", rd, 32'h00000000);
    check("target reset", {30'h0, memTarget}, 32'h00000000);
    $display("reset test done");
    ctrl(32'h000000e0, 32'h000000c0);
    check("target cfg", {30'h0, memTarget}, 32'h00000002);
    ctrl(32'h00000080, 32'h00000080);
    check("target flash", {30'h0, memTarget}, 32'h00000001);
    ctrl(32'h00000000, 32'h00000000);
    check("target eeprom", {30'h0, memTarget}, 32'h00000000);
    $display("select test done");
    apb(1'b1, nvc_pkg::ADDR_CTRL, 32'h00000096);
    // The start pulse is counted at the edge after the access edge.
    repeat (2) @(negedge core_clk);
    check("erase start", starts, 32'd1);
    check("erase kind", {31'h0, lastErase}, 32'h00000001);
    finish_op(1'b0);
    apb(1'b0, nvc_pkg::ADDR_CTRL, 32'h00000000);
    check("erase cleared", rd, 32'h00000084);
    $display("erase test done");
    ctrl(32'h00000086, 32'h00000086);
    check("write kind", {31'h0, lastErase}, 32'h00000000);
    finish_op(1'b0);
    ctrl(32'h00000082, 32'h00000088);
    check("no start", starts, 32'd2);
    $display("write test done");
    apb(1'b1, nvc_pkg::ADDR_CTRL, 32'h000000c6);
    finish_op(1'b1);
    apb(1'b0, nvc_pkg::ADDR_CTRL, 32'h00000000);
    check("abort flag", rd, 32'h000000cc);
    check("abort target", {30'h0, memTarget}, 32'h00000002);
    ctrl(32'h00000001, 32'h00000000);
    check("read pulse", reads, 32'd1);
    $display("abort test done");
    apb(1'b0, 12'h008, 32'h00000000);
    check("unmapped data", rd, 32'h00000000);
    check("unmapped err", {31'h0, err}, 32'h00000001);
    apb(1'b1, nvc_pkg::ADDR_TPTR, 32'hffffffff);
    apb(1'b0, nvc_pkg::ADDR_TPTR, 32'h00000000);
    check("pointer", rd, 32'h003fffff);
    check("pointer port", {10'h0, tablePointer}, 32'h003fffff);
    $display("bus test done");
    conclude();
  end
endmodule
